// ### verilog/bes_sram_ctrl.sv
// banked sram with secded ecc shared by the hub controller and management engine
`timescale 1ns/1ns
module bes_sram_ctrl (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire bes_pkg::bes_req_s hub_req_in,
    output logic hub_ready_out,
    output bes_pkg::bes_rsp_s hub_rsp_out,
    input wire bes_pkg::bes_req_s me_req_in,
    output logic me_ready_out,
    output bes_pkg::bes_rsp_s me_rsp_out,
    input wire logic [bes_pkg::BANK_COUNT-1:0] bank_power_on_in,
    output logic [bes_pkg::BANK_COUNT-1:0] bank_powered_out,
    input wire logic [bes_pkg::CODE_W-1:0] inject_flip_in
);

    ////////////////////////////////////////////////////////////////////////
    // ecc helpers: hamming over 38 positions plus overall parity
    // six check bits sit at positions 1, 2, 4, 8, 16 and 32

    // positions 1..38, powers of two are check bits
    function automatic logic [38:1] bes_place(input logic [31:0] d);
        logic [38:1] c;
        int k;
        c = '0;
        k = 0;
        for (int p = 1; p <= 38; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p] = d[k];
                k++;
            end
        end
        return c;
    endfunction

    // syndrome of a placed word including its check bits
    function automatic logic [5:0] bes_syn(input logic [38:1] c);
        logic [5:0] s;
        s = '0;
        for (int p = 1; p <= 38; p++) begin
            for (int b = 0; b < 6; b++) begin
                if (c[p] && ((p >> b) & 1) == 1) begin
                    s[b] = s[b] ^ 1'b1;
                end
            end
        end
        return s;
    endfunction

    // encode: {overall parity, placed word with check bits}
    function automatic logic [bes_pkg::CODE_W-1:0] bes_encode(input logic [31:0] d);
        logic [38:1] c;
        logic [5:0] s;
        c = bes_place(d);
        s = bes_syn(c);
        for (int b = 0; b < 6; b++) begin
            c[1 << b] = s[b];
        end
        return {^c, c};
    endfunction

    // extract data bits back from positions
    function automatic logic [31:0] bes_extract(input logic [38:1] c);
        logic [31:0] d;
        int k;
        d = '0;
        k = 0;
        for (int p = 1; p <= 38; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[k] = c[p];
                k++;
            end
        end
        return d;
    endfunction

    // flat array index of a word: bank times words per bank plus word index
    function automatic int bes_index(input logic [bes_pkg::BANK_W-1:0] b, input logic [bes_pkg::IDX_W-1:0] i);
        return int'(b) * bes_pkg::BANK_WORDS + int'(i);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // storage: one array, bank selects the upper index bits

    // twenty banks of 8192 words, each 32 data bits plus 7 ecc bits
    logic [bes_pkg::CODE_W-1:0] mem_r [bes_pkg::BANK_COUNT*bes_pkg::BANK_WORDS];

    logic [bes_pkg::BANK_COUNT-1:0] pwr_r, pwr_nxt;
    logic last_me_r, last_me_nxt;
    bes_pkg::bes_state_e state_r, state_nxt;
    logic pend_me_r, pend_me_nxt;
    logic pend_off_r, pend_off_nxt;
    logic [bes_pkg::CODE_W-1:0] rcode_r, rcode_nxt;
    bes_pkg::bes_rsp_s hub_rsp_r, hub_rsp_nxt;
    bes_pkg::bes_rsp_s me_rsp_r, me_rsp_nxt;

    logic grant_me;
    logic take;
    bes_pkg::bes_req_s sel;
    logic [bes_pkg::BANK_W-1:0] bank;
    logic bank_ok;
    logic [5:0] syn;
    logic par_bad;
    logic [38:1] fixed;
    bes_pkg::bes_rsp_s done;

    assign bank_powered_out = pwr_r;
    assign hub_rsp_out = hub_rsp_r;
    assign me_rsp_out = me_rsp_r;

    ////////////////////////////////////////////////////////////////////////
    // arbitration: round robin between hub and engine, one access per idle cycle

    always_comb begin
        // engine wins unless it had the last turn while the hub is waiting
        grant_me = me_req_in.valid && (!hub_req_in.valid || !last_me_r);
        take = (state_r == bes_pkg::BES_IDLE) && (hub_req_in.valid || me_req_in.valid);
        sel = grant_me ? me_req_in : hub_req_in;
        bank = sel.addr[bes_pkg::ADDR_W-1 -: bes_pkg::BANK_W];
        // out-of-range and gated banks both answer with bank_off
        bank_ok = (bank < 5'(bes_pkg::BANK_COUNT)) && pwr_r[bank];
        hub_ready_out = take && !grant_me;
        me_ready_out = take && grant_me;
    end

    ////////////////////////////////////////////////////////////////////////
    // ecc check of the word captured last cycle

    // code word layout: bit 38 overall parity, bits 37:0 hold positions 38 down to 1
    always_comb begin
        syn = bes_syn(rcode_r[37:0]);
        par_bad = ^rcode_r;
        fixed = rcode_r[37:0];
        // single flip: parity bad and the syndrome names the flipped position
        if (par_bad && syn != 6'h00 && syn <= 6'h26) begin
            fixed[syn] = ~fixed[syn];
        end
        done = '0;
        done.valid = 1'b1;
        done.bank_off = pend_off_r;
        done.rdata = pend_off_r ? '0 : bes_extract(fixed);
        // a syndrome beyond the last position cannot be corrected
        done.corrected = !pend_off_r && par_bad && syn <= 6'h26;
        done.uncorrectable = !pend_off_r && ((!par_bad && syn != 6'h00) || (par_bad && syn > 6'h26));
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        pwr_nxt = bank_power_on_in;
        last_me_nxt = last_me_r;
        state_nxt = bes_pkg::BES_IDLE;
        pend_me_nxt = pend_me_r;
        pend_off_nxt = pend_off_r;
        rcode_nxt = rcode_r;
        // responses are one-cycle pulses, so their next values default to zero
        hub_rsp_nxt = '0;
        me_rsp_nxt = '0;
        if (state_r == bes_pkg::BES_READ) begin
            if (pend_me_r) begin
                me_rsp_nxt = done;
            end else begin
                hub_rsp_nxt = done;
            end
        end
        if (take) begin
            last_me_nxt = grant_me;
            pend_me_nxt = grant_me;
            pend_off_nxt = !bank_ok;
            // writes answer in the next cycle, also when the bank refuses them
            if (sel.kind == bes_pkg::BES_ACC_WRITE) begin
                if (grant_me) begin
                    me_rsp_nxt.valid = 1'b1;
                    me_rsp_nxt.bank_off = !bank_ok;
                end else begin
                    hub_rsp_nxt.valid = 1'b1;
                    hub_rsp_nxt.bank_off = !bank_ok;
                end
            end else begin
                // capture now, check next cycle; the flip mask exercises the decoder
                state_nxt = bes_pkg::BES_READ;
                rcode_nxt = mem_r[bes_index(bank, sel.addr[bes_pkg::IDX_W-1:0])] ^ inject_flip_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and array write

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pwr_r <= bes_pkg::PWR_RESET;
            last_me_r <= bes_pkg::GRANT_RESET;
            state_r <= bes_pkg::BES_IDLE;
            pend_me_r <= 1'b0;
            pend_off_r <= 1'b0;
            rcode_r <= '0;
            hub_rsp_r <= '0;
            me_rsp_r <= '0;
        end else begin
            pwr_r <= pwr_nxt;
            last_me_r <= last_me_nxt;
            state_r <= state_nxt;
            pend_me_r <= pend_me_nxt;
            pend_off_r <= pend_off_nxt;
            rcode_r <= rcode_nxt;
            hub_rsp_r <= hub_rsp_nxt;
            me_rsp_r <= me_rsp_nxt;
        end
    end

    // array has no reset; written only into powered banks
    // a refused write leaves the old contents of the word in place
    always_ff @(posedge clk_in) begin
        if (!reset_in && take && sel.kind == bes_pkg::BES_ACC_WRITE && bank_ok) begin
            mem_r[bes_index(bank, sel.addr[bes_pkg::IDX_W-1:0])] <= bes_encode(sel.wdata);
        end
    end

endmodule

// ### verilog/bes_pkg.sv
// package of constants and types for the banked ecc sram controller
//
// Notes on behaviour
// - 640 kB storage in twenty equal 32 kB banks, each independently addressed.
// - every access moves one 32-bit data word between requester and array.
// - reads check stored ecc and return corrected data on any single-bit error.
// - reads flag two-bit errors as detected and uncorrectable.
// - each bank has its own firmware-controlled power gate; others keep working.
// - management engine is a second requester sharing the array.
// - both instruction fetches and data reads and writes are served.
package bes_pkg;

    localparam int BANK_COUNT = 20;
    localparam int BANK_BYTES = 32768;
    localparam int WORD_BYTES = 4;
    localparam int BANK_WORDS = BANK_BYTES / WORD_BYTES;
    localparam int DATA_W = 32;
    localparam int ECC_W = 7;
    localparam int CODE_W = DATA_W + ECC_W;
    localparam int BANK_W = 5;
    localparam int IDX_W = 13;
    localparam int ADDR_W = BANK_W + IDX_W;

    localparam logic [BANK_COUNT-1:0] PWR_RESET = 20'hfffff;
    localparam logic [0:0] GRANT_RESET = 1'h0;

    typedef enum logic [1:0] {
        BES_ACC_FETCH = 2'h0,
        BES_ACC_READ = 2'h1,
        BES_ACC_WRITE = 2'h2
    } bes_acc_e;

    typedef enum logic [1:0] {
        BES_IDLE = 2'h0,
        BES_READ = 2'h1
    } bes_state_e;

    typedef struct packed {
        logic valid;
        bes_acc_e kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bes_req_s;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] rdata;
        logic corrected;
        logic uncorrectable;
        logic bank_off;
    } bes_rsp_s;

endpackage

// ### sim/bes_req_model.sv
// requester model for the hub controller or management engine
`timescale 1ns/1ns
module bes_req_model (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic go_in,
    input wire bes_pkg::bes_acc_e kind_in,
    input wire logic [17:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic ready_in,
    output bes_pkg::bes_req_s req_out
);
    // hold request until taken, then scramble the released data
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            req_out <= 53'h0;
        end else if (go_in) begin
            req_out <= {1'b1, kind_in, addr_in, wdata_in};
        end else if (req_out.valid && ready_in) begin
            req_out.valid <= 1'b0;
            req_out.wdata <= ~req_out.wdata;
        end
    end
endmodule

// ### sim/bes_checker.sv
// assertions on the ports of the sram controller
`timescale 1ns/1ns
module bes_checker (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire bes_pkg::bes_req_s hub_req_in,
    input wire logic hub_ready_out,
    input wire bes_pkg::bes_rsp_s hub_rsp_out,
    input wire bes_pkg::bes_req_s me_req_in,
    input wire logic me_ready_out,
    input wire bes_pkg::bes_rsp_s me_rsp_out,
    input wire logic [19:0] bank_power_on_in,
    input wire logic [19:0] bank_powered_out,
    input wire logic [38:0] inject_flip_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // request taken strobes
    wire hub_take = hub_ready_out && hub_req_in.valid;
    wire hub_wr = hub_req_in.kind == bes_pkg::BES_ACC_WRITE;
    wire me_take = me_ready_out && me_req_in.valid;
    ////////////////////////////////////////////////////////////////
    property p_wr; hub_take && hub_wr |=> hub_rsp_out.valid; endproperty
    a_wr: assert property (p_wr) else $error("hub write answer late");
    property p_me_wr; me_take && me_req_in.kind == bes_pkg::BES_ACC_WRITE |=> me_rsp_out.valid; endproperty
    a_me_wr: assert property (p_me_wr) else $error("engine write answer late");
    property p_rd; hub_take && !hub_wr |=> !hub_rsp_out.valid ##1 hub_rsp_out.valid; endproperty
    a_rd: assert property (p_rd) else $error("read answer timing");
    property p_busy; hub_take && !hub_wr |=> !hub_ready_out && !me_ready_out; endproperty
    a_busy: assert property (p_busy) else $error("taken during ecc cycle");
    property p_grant; !(hub_ready_out && me_ready_out); endproperty
    a_grant: assert property (p_grant) else $error("both requesters granted");
    property p_pwr; !$past(reset_in) |-> bank_powered_out == $past(bank_power_on_in); endproperty
    a_pwr: assert property (p_pwr) else $error("bank power state wrong");
    property p_off; hub_rsp_out.bank_off |-> hub_rsp_out.rdata == 32'h0 && !hub_rsp_out.corrected; endproperty
    a_off: assert property (p_off) else $error("off bank answer not blank");
    property p_range; hub_take && hub_wr && hub_req_in.addr[17:13] >= 5'h14 |=> hub_rsp_out.bank_off; endproperty
    a_range: assert property (p_range) else $error("bank beyond range accepted");
    property p_unc; hub_rsp_out.uncorrectable |-> hub_rsp_out.valid && !hub_rsp_out.corrected; endproperty
    a_unc: assert property (p_unc) else $error("uncorrectable flag misplaced");
    property p_clean;
        hub_take && !hub_wr && inject_flip_in == 39'h0 |=> ##1 !hub_rsp_out.corrected && !hub_rsp_out.uncorrectable;
    endproperty
    a_clean: assert property (p_clean) else $error("clean read flagged");
    c_both: cover property (hub_req_in.valid && me_req_in.valid);
    c_corr: cover property (hub_rsp_out.corrected);
    c_unc: cover property (hub_rsp_out.uncorrectable);
    c_me: cover property (me_rsp_out.valid);
endmodule

// ### sim/test_banked_ecc_sram_controller.sv
// self-checking bench for the banked ecc sram controller
`timescale 1ns/1ns
module test_banked_ecc_sram_controller;
    logic clk_in = 1'b0, reset_in = 1'b1, h_go = 1'b0, m_go = 1'b0, hub_ready_out, me_ready_out;
    bes_pkg::bes_acc_e kind = bes_pkg::BES_ACC_READ;
    logic [17:0] addr = 18'h0;
    logic [31:0] wdata = 32'h0;
    logic [19:0] bank_power_on_in = 20'hfffff, bank_powered_out;
    logic [38:0] inject_flip_in = 39'h0;
    bes_pkg::bes_req_s hub_req_in, me_req_in;
    bes_pkg::bes_rsp_s hub_rsp_out, me_rsp_out, rsp;
    int num_errors = 0, n_tests = 0;
    bes_sram_ctrl dut_u (.clk_in, .reset_in, .hub_req_in, .hub_ready_out, .hub_rsp_out, .me_req_in,
        .me_ready_out, .me_rsp_out, .bank_power_on_in, .bank_powered_out, .inject_flip_in);
    bes_req_model hub_u (.clk_in, .reset_in, .go_in(h_go), .kind_in(kind), .addr_in(addr),
        .wdata_in(wdata), .ready_in(hub_ready_out), .req_out(hub_req_in));
    bes_req_model me_u (.clk_in, .reset_in, .go_in(m_go), .kind_in(kind), .addr_in(addr),
        .wdata_in(wdata), .ready_in(me_ready_out), .req_out(me_req_in));
    // 125 MHz clock
    initial forever #4 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            num_errors++;
        end
    endtask
    // one access, waits for the answer
    task automatic acc(input bit me, input bes_pkg::bes_acc_e k, input logic [17:0] a, input logic [31:0] d);
        int n = 0;
        kind <= k;
        addr <= a;
        wdata <= d;
        h_go <= !me;
        m_go <= me;
        @(posedge clk_in);
        h_go <= 1'b0;
        m_go <= 1'b0;
        do begin
            @(negedge clk_in);
            rsp = me ? me_rsp_out : hub_rsp_out;
            n++;
        end while (rsp.valid !== 1'b1 && n < 20);
        chk("answer", {31'h0, rsp.valid}, 32'h1);
        @(posedge clk_in);
    endtask
    task automatic t_ecc();
        acc(0, bes_pkg::BES_ACC_WRITE, 18'h06005, 32'ha5c31e97);
        acc(0, bes_pkg::BES_ACC_READ, 18'h06005, 32'h0);
        chk("read", rsp.rdata, 32'ha5c31e97);
        inject_flip_in <= 39'h400;
        acc(0, bes_pkg::BES_ACC_FETCH, 18'h06005, 32'h0);
        chk("fetch", rsp.rdata, 32'ha5c31e97);
        chk("corr", {31'h0, rsp.corrected}, 32'h1);
        inject_flip_in <= 39'h408;
        acc(0, bes_pkg::BES_ACC_READ, 18'h06005, 32'h0);
        chk("unc", {31'h0, rsp.uncorrectable}, 32'h1);
        inject_flip_in <= 39'h0;
    endtask
    task automatic t_me();
        acc(1, bes_pkg::BES_ACC_WRITE, 18'h27fff, 32'h5a3c0f12);
        acc(0, bes_pkg::BES_ACC_READ, 18'h27fff, 32'h0);
        chk("shared", rsp.rdata, 32'h5a3c0f12);
        acc(1, bes_pkg::BES_ACC_READ, 18'h06005, 32'h0);
        chk("me_read", rsp.rdata, 32'ha5c31e97);
        acc(0, bes_pkg::BES_ACC_WRITE, 18'h28000, 32'hffffffff);
        chk("range", {31'h0, rsp.bank_off}, 32'h1);
    endtask
    task automatic t_pwr();
        acc(1, bes_pkg::BES_ACC_WRITE, 18'h04000, 32'h0badf00d);
        bank_power_on_in <= 20'hffffb;
        @(negedge clk_in);
        @(negedge clk_in);
        chk("gate", {12'h0, bank_powered_out}, 32'h000ffffb);
        @(posedge clk_in);
        acc(1, bes_pkg::BES_ACC_WRITE, 18'h04000, 32'h12345678);
        chk("off", {31'h0, rsp.bank_off}, 32'h1);
        acc(0, bes_pkg::BES_ACC_READ, 18'h04000, 32'h0);
        chk("off_rd", {31'h0, rsp.bank_off}, 32'h1);
        chk("off_data", rsp.rdata, 32'h0);
        acc(0, bes_pkg::BES_ACC_READ, 18'h06005, 32'h0);
        chk("other", rsp.rdata, 32'ha5c31e97);
        bank_power_on_in <= 20'hfffff;
        acc(1, bes_pkg::BES_ACC_READ, 18'h04000, 32'h0);
        chk("kept", rsp.rdata, 32'h0badf00d);
    endtask
    // both requesters at once: each answered once, in turn
    task automatic t_both();
        int nh = 0;
        int nm = 0;
        kind <= bes_pkg::BES_ACC_WRITE;
        addr <= 18'h02010;
        wdata <= 32'h0f1e2d3c;
        h_go <= 1'b1;
        m_go <= 1'b1;
        @(posedge clk_in);
        h_go <= 1'b0;
        m_go <= 1'b0;
        repeat (6) begin
            @(negedge clk_in);
            if (hub_rsp_out.valid === 1'b1) nh++;
            if (me_rsp_out.valid === 1'b1) nm++;
        end
        chk("hub_turn", nh, 32'h1);
        chk("me_turn", nm, 32'h1);
        @(posedge clk_in);
        acc(1, bes_pkg::BES_ACC_READ, 18'h02010, 32'h0);
        chk("both", rsp.rdata, 32'h0f1e2d3c);
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        @(negedge clk_in);
        chk("pwr_rst", {12'h0, bank_powered_out}, 32'h000fffff);
        @(posedge clk_in);
        t_ecc();
        t_me();
        t_pwr();
        t_both();
        end_of_test();
    end
    // watchdog
    initial begin
        #20000;
        chk("watchdog", 32'h1, 32'h0);
        end_of_test();
    end
endmodule
bind bes_sram_ctrl bes_checker chk_u (.clk_in(clk_in), .reset_in(reset_in), .hub_req_in(hub_req_in),
    .hub_ready_out(hub_ready_out), .hub_rsp_out(hub_rsp_out), .me_req_in(me_req_in), .me_ready_out(me_ready_out),
    .me_rsp_out(me_rsp_out), .bank_power_on_in(bank_power_on_in), .bank_powered_out(bank_powered_out),
    .inject_flip_in(inject_flip_in));
